/* logic/mcbf_defines.vh */
// Constants of the modulator control bus and burst input front end
`ifndef MCBF_DEFINES_VH
`define MCBF_DEFINES_VH
`define MCBF_DEV_FIXED 5'h00
`define MCBF_NUM_REGS 74
`define MCBF_REG_LAST 7'h49
`define MCBF_WO1_LO 7'h06
`define MCBF_WO1_HI 7'h11
`define MCBF_WO2_LO 7'h1E
`define MCBF_WO2_HI 7'h47
`define MCBF_REG_FEC_CTRL 7'h01
`define MCBF_BIT_FEC_EN 2
`define MCBF_BIT_RS_ORDER 3
`define MCBF_REG_MSG_LEN 7'h02
`define MCBF_REG_T 7'h03
`define MCBF_REG_PER_LO 7'h04
`define MCBF_REG_PER_HI 7'h05
`define MCBF_REG_CTRL 7'h48
`define MCBF_BIT_CLKX6 0
`define MCBF_RESET_BYTE 8'h00
`define MCBF_PRIM_POLY 8'h1D
`define MCBF_T_MAX 10
`endif

/* logic/mcbf_top.v */
// Control bus slave, burst input framing and Reed-Solomon encoder
`timescale 1ns/1ps
`include "mcbf_defines.vh"

// Functional notes
// R1 - Start is data falling with clock high; stop is data rising with clock high.
// R2 - Each byte is eight bits plus acknowledge; device pulls acknowledge low on ninth pulse.
// R3 - Master releases data line on ninth pulse of bytes it sends.
// R4 - Select byte: bits 7-3 zero, bit 2 one, bit 1 strap, bit 0 read.
// R5 - Register address acknowledged only from 00h to 49h.
// R6 - A write has select byte, address and at least one data byte.
// R7 - Further data bytes go to successively higher register addresses.
// R8 - Register 49h is written and read in a transfer of its own.
// R9 - Read: write address, repeated start, read select, acknowledge, eight data bits.
// R10 - Master acknowledge continues readback; no-acknowledge then stop ends it.
// R11 - Registers 06h-11h and 1Eh-47h are write-only and return no data.
// R12 - Host keeps frame enable low during every control bus transfer.
// R13 - Frame enable rising edge found by fast sampling; data sampled at programmed interval.
// R14 - Host frames bursts exactly and supplies data at an even clock submultiple.
// R15 - Encoder uses field poly x^8+x^4+x^3+x^2+1, generator roots a^0..a^(2t-1).
// R16 - Codeword is message length plus 2t; K 16 to 255, t 0 to 10.
// R17 - With t zero and K nonzero data passes through unencoded.
// R18 - Input is ignored during the check byte gaps while parity is inserted.
// R19 - FEC enabled by register bit or pin; a bit selects order against randomizer.
// R20 - Reset clears register 48h and the control bus.
// R21 - Reset zeroes encoder output and the stored preamble.
// R22 - Host gives three resets then programs all registers.
// R23 - First data sample half a bit period after frame enable rises.
// R24 - Host holds frame enable low for preamble plus eight symbols between bursts.
// R25 - Unmatched select byte: no acknowledge, line released until next start.
module mcbf_top
#(
    parameter TMAX = `MCBF_T_MAX
)
(
    input wire clk, // System clock
    input wire resetn, // Asynchronous reset, active low
    input wire ce, // Clock enable, freezes all state when low
    input wire scl_in, // Control bus clock pin
    input wire sda_in, // Control bus data pin level
    output reg sda_out, // Control bus data drive value, always low
    output reg sda_oe, // High while pulling data line low
    input wire addr_sel, // Strapped address select level
    input wire fec_pin, // Correction enable pin
    input wire burst_frame_enable, // Burst frame enable pin
    input wire serial_data, // Serial burst data pin
    output reg [7:0] byte_data, // Encoded byte out
    output reg byte_valid, // Byte out valid
    input wire byte_ready, // Receiver ready
    output reg overflow, // Sticky: data byte lost to full buffer
    output reg clock_multiplier_x6, // Clock multiplier enable
    output reg fec_after_rand // Encoder placed after randomizer
);
    localparam NP = 2 * TMAX;
    localparam S_IDLE = 3'h0;
    localparam S_DEV = 3'h1;
    localparam S_REG = 3'h2;
    localparam S_WR = 3'h3;
    localparam S_RD = 3'h4;
    localparam S_IGN = 3'h5;

    // Three-stage synchronisers for the bus, frame, serial data and correction pins; stage 0 feeds only stage 1
    reg [2:0] scl_s, sda_s, fe_s, sd_s, fp_s;
    reg scl_f, sda_f, fe_f, sd_f;
    wire scl_rise = scl_s[1] & scl_s[2] & ~scl_f;
    wire scl_fall = ~scl_s[1] & ~scl_s[2] & scl_f;
    wire sda_rise = sda_s[1] & sda_s[2] & ~sda_f;
    wire sda_fall = ~sda_s[1] & ~sda_s[2] & sda_f;
    wire fe_rise = fe_s[1] & fe_s[2] & ~fe_f;
    wire fe_fall = ~fe_s[1] & ~fe_s[2] & fe_f;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            fe_s <= 3'h0;
            sd_s <= 3'h0;
            fp_s <= 3'h0;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            fe_f <= 1'b0;
            sd_f <= 1'b0;
        end
        else if (ce)
        begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            fe_s <= {fe_s[1:0], burst_frame_enable};
            sd_s <= {sd_s[1:0], serial_data};
            fp_s <= {fp_s[1:0], fec_pin};
            if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
            if (fe_s[1] == fe_s[2]) fe_f <= fe_s[2];
            if (sd_s[1] == sd_s[2]) sd_f <= sd_s[2];
        end
    end

    // GF(2^8) multiply over the primitive polynomial
    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        integer k;
        reg [7:0] acc, aa;
        begin
            acc = 8'h00;
            aa = a;
            for (k = 0; k < 8; k = k + 1)
            begin
                if (b[k]) acc = acc ^ aa;
                aa = aa[7] ? ({aa[6:0], 1'b0} ^ `MCBF_PRIM_POLY) : {aa[6:0], 1'b0};
            end
            gf_mul = acc;
        end
    endfunction

    // Control bus slave
    reg [7:0] regs [0:`MCBF_NUM_REGS-1];
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [7:0] txreg;
    reg [6:0] ptr;
    reg rdmode;
    reg ack_ok;
    // Readback gate: write-only and unused addresses leave the line released.
    // The register value comes in as an argument so the gate follows later writes.
    function [7:0] rd_gate;
        input [6:0] a;
        input [7:0] v;
        begin
            if (a > `MCBF_REG_LAST || (a >= `MCBF_WO1_LO && a <= `MCBF_WO1_HI) ||
                (a >= `MCBF_WO2_LO && a <= `MCBF_WO2_HI))
                rd_gate = 8'hFF; // R11
            else
                rd_gate = v;
        end
    endfunction
    wire [7:0] rd_byte = rd_gate(ptr, regs[ptr]); // R11
    wire [7:0] rd_next = rd_gate(ptr + 7'h1, regs[ptr + 7'h1]); // R11
    integer i;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (i = 0; i < `MCBF_NUM_REGS; i = i + 1)
                regs[i] <= `MCBF_RESET_BYTE; // R20 R21
            state <= S_IDLE; // R20
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            ptr <= 7'h00;
            rdmode <= 1'b0;
            ack_ok <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end
        else if (ce)
        begin
            if (scl_f && sda_fall)
            begin
                // Start or repeated start
                state <= S_DEV; // R1
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (scl_f && sda_rise)
            begin
                state <= S_IDLE; // R1 R10
                sda_oe <= 1'b0;
            end
            else if (scl_rise && state != S_IDLE && state != S_IGN)
            begin
                if (bitcnt < 4'h8)
                    shreg <= {shreg[6:0], sda_f};
                if (state == S_RD && bitcnt == 4'h8 && sda_f)
                    state <= S_IGN; // R10
                bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && state != S_IDLE && state != S_IGN)
            begin
                if (bitcnt == 4'h8 && state != S_RD)
                begin
                    // Ninth pulse: decide acknowledge
                    ack_ok <= 1'b1;
                    sda_oe <= 1'b1; // R2
                    case (state)
                        S_DEV:
                        begin
                            rdmode <= shreg[0];
                            if (shreg[7:3] != `MCBF_DEV_FIXED || !shreg[2] || shreg[1] != addr_sel)
                            begin
                                sda_oe <= 1'b0; // R4 R25
                                state <= S_IGN;
                            end
                        end
                        S_REG:
                        begin
                            ptr <= shreg[6:0];
                            if (shreg > {1'b0, `MCBF_REG_LAST})
                            begin
                                sda_oe <= 1'b0; // R5
                                state <= S_IGN;
                            end
                        end
                        default:
                        begin
                            if (ptr <= `MCBF_REG_LAST)
                            begin
                                regs[ptr] <= shreg; // R7
                                ptr <= ptr + 7'h1;
                            end
                        end
                    endcase
                end
                else if (bitcnt == 4'h8)
                    sda_oe <= 1'b0; // Release for master acknowledge
                else if (bitcnt == 4'h9)
                begin
                    bitcnt <= 4'h0;
                    sda_oe <= 1'b0;
                    if (state == S_DEV && rdmode)
                    begin
                        state <= S_RD; // R9
                        txreg <= {rd_byte[6:0], 1'b1};
                        sda_oe <= ~rd_byte[7];
                    end
                    else if (state == S_RD)
                    begin
                        // Master acknowledged: next register
                        txreg <= {rd_next[6:0], 1'b1};
                        sda_oe <= ~rd_next[7]; // R10 R11
                        ptr <= ptr + 7'h1;
                    end
                    else if (state == S_DEV)
                        state <= S_REG;
                    else
                        state <= S_WR; // R6
                end
                else if (state == S_RD)
                begin
                    sda_oe <= ~txreg[7];
                    txreg <= {txreg[6:0], 1'b1};
                end
            end
        end
    end

    // Configuration decode, registered onto ports
    wire fec_on = regs[`MCBF_REG_FEC_CTRL][`MCBF_BIT_FEC_EN] | fp_s[2]; // R19
    wire [7:0] msg_len = regs[`MCBF_REG_MSG_LEN];
    wire [3:0] tval = (regs[`MCBF_REG_T][3:0] > TMAX) ? TMAX[3:0] : regs[`MCBF_REG_T][3:0];
    wire [4:0] np = {tval, 1'b0};
    wire rs_on = fec_on && tval != 4'h0 && msg_len != 8'h00; // R17
    wire [15:0] period = {regs[`MCBF_REG_PER_HI], regs[`MCBF_REG_PER_LO]};
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clock_multiplier_x6 <= 1'b0; // R20
            fec_after_rand <= 1'b0;
        end
        else if (ce)
        begin
            clock_multiplier_x6 <= regs[`MCBF_REG_CTRL][`MCBF_BIT_CLKX6];
            fec_after_rand <= regs[`MCBF_REG_FEC_CTRL][`MCBF_BIT_RS_ORDER]; // R19
        end
    end

    // Burst sampler, generator build and encoder
    reg active, in_gap, par_out;
    reg [15:0] tick;
    reg [2:0] nbit;
    reg [7:0] inbyte;
    reg [7:0] mcnt;
    reg [4:0] gcnt, pcnt, gapcnt, gstep;
    reg [7:0] apow;
    reg [7:0] gen [0:NP];
    reg [7:0] par [0:NP-1];
    reg push;
    reg [7:0] push_d;
    wire in_ready;
    wire sample = active && tick == 16'h0000;
    wire byte_done = sample && nbit == 3'h7;
    wire [7:0] fullbyte = {inbyte[6:0], sd_f};
    wire [7:0] fb = fullbyte ^ par[np - 5'h1];
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            active <= 1'b0;
            in_gap <= 1'b0;
            par_out <= 1'b0;
            tick <= 16'h0000;
            nbit <= 3'h0;
            inbyte <= 8'h00;
            mcnt <= 8'h00;
            gcnt <= 5'h00;
            pcnt <= 5'h00;
            gapcnt <= 5'h00;
            gstep <= 5'h00;
            apow <= 8'h01;
            push <= 1'b0;
            push_d <= 8'h00;
            overflow <= 1'b0;
            for (i = 0; i <= NP; i = i + 1)
                gen[i] <= 8'h00;
            for (i = 0; i < NP; i = i + 1)
                par[i] <= 8'h00;
        end
        else if (ce)
        begin
            push <= 1'b0;
            if (fe_rise)
            begin
                // New burst: half-period offset, rebuild generator
                active <= 1'b1;
                tick <= {1'b0, period[15:1]}; // R13 R23
                nbit <= 3'h0;
                mcnt <= 8'h00;
                in_gap <= 1'b0;
                par_out <= 1'b0;
                gstep <= 5'h00;
                apow <= 8'h01;
                gen[0] <= 8'h01;
                for (i = 1; i <= NP; i = i + 1)
                    gen[i] <= 8'h00;
                for (i = 0; i < NP; i = i + 1)
                    par[i] <= 8'h00;
            end
            else
            begin
                if (fe_fall)
                    active <= 1'b0;
                if (gstep < np)
                begin
                    // Multiply generator by (x + a^gstep)
                    gen[0] <= gf_mul(gen[0], apow); // R15
                    for (i = 1; i <= NP; i = i + 1)
                        gen[i] <= gen[i-1] ^ gf_mul(gen[i], apow);
                    apow <= gf_mul(apow, 8'h02);
                    gstep <= gstep + 5'h01;
                end
                if (active)
                    tick <= (tick == 16'h0000) ? period - 16'h0001 : tick - 16'h0001; // R13
                if (sample)
                begin
                    inbyte <= fullbyte;
                    nbit <= nbit + 3'h1;
                end
                if (byte_done && in_gap)
                begin
                    // Filler byte ignored
                    gapcnt <= gapcnt - 5'h01; // R18
                    if (gapcnt == 5'h01) in_gap <= 1'b0;
                end
                else if (byte_done)
                begin
                    if (!in_ready) overflow <= 1'b1;
                    push <= in_ready;
                    push_d <= fullbyte;
                    if (rs_on)
                    begin
                        par[0] <= gf_mul(fb, gen[0]); // R15
                        for (i = 1; i < NP; i = i + 1)
                            par[i] <= par[i-1] ^ gf_mul(fb, gen[i]);
                        mcnt <= mcnt + 8'h01;
                        if (mcnt + 8'h01 == msg_len)
                        begin
                            // Message complete: codeword gets 2t check bytes
                            mcnt <= 8'h00; // R16
                            in_gap <= 1'b1;
                            gapcnt <= np;
                            par_out <= 1'b1;
                            pcnt <= np;
                        end
                    end
                end
                else if (par_out && in_ready && !push)
                begin
                    // Shift check bytes out, stalls on a full buffer
                    push <= 1'b1; // R18
                    push_d <= par[np - 5'h1];
                    par[0] <= 8'h00;
                    for (i = 1; i < NP; i = i + 1)
                        par[i] <= par[i-1];
                    pcnt <= pcnt - 5'h01;
                    if (pcnt == 5'h01) par_out <= 1'b0;
                end
            end
        end
    end

    // Two-entry output buffer: head register plus skid entry
    reg [7:0] skid_d;
    reg skid_v;
    assign in_ready = ~skid_v & ~push;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            byte_data <= 8'h00; // R21
            byte_valid <= 1'b0;
            skid_d <= 8'h00;
            skid_v <= 1'b0;
        end
        else if (ce)
        begin
            if (!byte_valid || byte_ready)
            begin
                if (skid_v)
                begin
                    byte_data <= skid_d;
                    byte_valid <= 1'b1;
                    skid_v <= push;
                    skid_d <= push_d;
                end
                else
                begin
                    byte_data <= push ? push_d : byte_data;
                    byte_valid <= push;
                end
            end
            else if (push)
            begin
                skid_d <= push_d;
                skid_v <= 1'b1;
            end
        end
    end
endmodule // mcbf_top

/* sim/mcbf_asserts.sv */
// Concurrent checks on the ports of mcbf_top
`timescale 1ns/1ps
module mcbf_asserts
#(
    parameter TMAX = 10
)
(
    input wire clk, // System clock
    input wire resetn, // Reset, active low
    input wire scl_in, // Bus clock
    input wire sda_in, // Bus data wire
    input wire sda_out, // Drive value
    input wire sda_oe, // Drive enable
    input wire [7:0] byte_data, // Output byte
    input wire byte_valid, // Output valid
    input wire byte_ready, // Receiver ready
    input wire overflow, // Lost byte flag
    input wire clock_multiplier_x6, // Multiplier enable
    input wire fec_after_rand // Encoder order
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_reset_clears: assert property (
        $rose(resetn) |-> !clock_multiplier_x6 && !fec_after_rand && !overflow && !byte_valid && !sda_oe)
        else $error("outputs not cleared by reset");
    // A stalled byte must neither vanish nor change
    a_byte_holds: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
        else $error("output byte lost while stalled");
    a_pull_in_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    // A change while the clock is high would read as start or stop
    a_hold_in_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    a_drive_low: assert property (sda_oe |-> !sda_out && !sda_in)
        else $error("driven data line not low");
    a_overflow_sticky: assert property (overflow |=> overflow)
        else $error("overflow flag cleared");
    a_ctrl_in_low: assert property (!$stable({clock_multiplier_x6, fec_after_rand}) |-> !scl_in)
        else $error("control bit changed outside a byte end");
    a_start_frees: assert property (
        scl_in && $past(scl_in) && $fell(sda_in) |=> !sda_oe [*8])
        else $error("data driven right after start");
endmodule // mcbf_asserts

bind mcbf_top mcbf_asserts #(.TMAX(TMAX)) u_chk
(
    .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(byte_ready), .overflow(overflow),
    .clock_multiplier_x6(clock_multiplier_x6), .fec_after_rand(fec_after_rand)
);

/* sim/mcbf_host_model.sv */
// Control bus master model with a pulled-up data wire
`timescale 1ns/1ps
module mcbf_host_model
(
    input wire clk, // System clock
    input wire sda_oe, // Device pulls data
    input wire sda_out, // Device drive value
    output reg scl, // Bus clock
    output wire sda // Resolved data wire
);
    reg sda_m; // Master data, 1 = released
    reg odd; // Longer high phase every other bit gives a 125 ns mean period
    // Pull-up wins unless a party pulls low
    assign sda = (!sda_m || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
        odd = 1'b0;
    end
    // One bit; data moves only while the clock is low
    task bit_io(input b, output r);
    begin
        repeat (3) @(posedge clk);
        sda_m <= b;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (odd ? 7 : 6) @(posedge clk);
        r = sda;
        scl <= 1'b0;
        odd = !odd;
    end
    endtask
    // Start for s = 1, stop for s = 0
    task edge_cond(input s);
    begin
        repeat (3) @(posedge clk);
        sda_m <= s;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (6) @(posedge clk);
        sda_m <= !s;
        repeat (6) @(posedge clk);
        scl <= !s; // Low after a start, stays high after a stop
    end
    endtask
    task send_byte(input [7:0] b, output ack);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    end
    endtask
    // Last byte gets a no-acknowledge
    task recv_byte(input last, output [7:0] b);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    end
    endtask
endmodule // mcbf_host_model

/* sim/test_mcbf_top.sv */
// Self-checking bench for the control bus and burst input front end
`timescale 1ns/1ps
module test_mcbf_top;
    localparam PER = 16; // Clocks per serial bit, even
    reg clk, resetn, ce, addr_sel, fec_pin, fe, sdat, rdy, ack, e;
    reg hold, throttle; // Receiver stalled, receiver taking every other cycle
    wire scl, sda, sda_out, sda_oe, byte_valid, overflow, x6, after_rand;
    wire [7:0] byte_data;
    integer bad_count, total_checks, i;
    integer cycles = 0;
    reg [7:0] rd, p1, p0, fb;
    reg [7:0] got[$];
    reg [7:0] msg[$];
    reg [7:0] badsel [4] = '{8'h0E, 8'h04, 8'h02, 8'h86};
    reg [23:0] tbl [4] = '{24'h0500FF, 24'h11FF00, 24'h1D00FF, 24'h47FF01};

    mcbf_top dut
    (
        .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel(addr_sel), .fec_pin(fec_pin), .burst_frame_enable(fe), .serial_data(sdat),
        .byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(rdy), .overflow(overflow),
        .clock_multiplier_x6(x6), .fec_after_rand(after_rand)
    );
    mcbf_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    // Collect taken bytes; cut a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        rdy <= !hold && (!throttle || cycles[0]);
        if (byte_valid === 1'b1 && rdy)
            got.push_back(byte_data);
        if (cycles == 30000)
        begin
            bad_count = bad_count + 1;
            conclude;
        end
    end
    task check(input [7:0] seen, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task conclude;
    begin
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // Write n bytes of msg from addr; out-of-range addresses get no acknowledge
    task wr(input [7:0] addr, input integer n);
        integer k;
    begin
        e = (addr <= 8'h49);
        host.edge_cond(1'b1);
        host.send_byte({5'h00, 1'b1, addr_sel, 1'b0}, ack);
        check(ack, 1);
        host.send_byte(addr, ack);
        check(ack, e);
        for (k = 0; k < n; k = k + 1)
        begin
            host.send_byte(msg[k], ack);
            check(ack, e);
        end
        host.edge_cond(1'b0);
    end
    endtask
    // Read n bytes from addr and compare with msg
    task rdn(input [7:0] addr, input integer n);
        integer k;
    begin
        host.edge_cond(1'b1);
        host.send_byte({5'h00, 1'b1, addr_sel, 1'b0}, ack);
        host.send_byte(addr, ack);
        host.edge_cond(1'b1);
        host.send_byte({5'h00, 1'b1, addr_sel, 1'b1}, ack);
        check(ack, 1);
        for (k = 0; k < n; k = k + 1)
        begin
            host.recv_byte(k == n - 1, rd);
            check(rd, msg[k]);
        end
        host.edge_cond(1'b0);
    end
    endtask
    // Frame n bytes of msg, first bit with the frame rise, then a long gap
    task burst(input integer n);
        integer k;
    begin
        for (k = 0; k < n * 8; k = k + 1)
        begin
            fe <= 1'b1;
            sdat <= msg[k / 8][7 - k % 8];
            repeat (PER) @(posedge clk);
        end
        fe <= 1'b0;
        repeat (300) @(posedge clk);
    end
    endtask
    // Product in the byte field
    function [7:0] gmul(input [7:0] a, input [7:0] b);
        integer k;
    begin
        gmul = 8'h00;
        for (k = 7; k >= 0; k = k - 1)
            gmul = {gmul[6:0], 1'b0} ^ (gmul[7] ? 8'h1D : 8'h00) ^ (b[k] ? a : 8'h00);
    end
    endfunction

    initial
    begin
        bad_count = 0;
        total_checks = 0;
        resetn = 1'b0;
        ce = 1'b1;
        addr_sel = 1'b1;
        fec_pin = 1'b0;
        fe = 1'b0;
        sdat = 1'b0;
        hold = 1'b0;
        throttle = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        msg = '{8'hAA, 8'h01};
        wr(8'h47, 2);
        check(x6, 1);
        // Foreign select bytes are ignored, data after them too
        foreach (badsel[j])
        begin
            host.edge_cond(1'b1);
            host.send_byte(badsel[j], ack);
            check(ack, 0);
            host.send_byte(8'h48, ack);
            check(ack, 0);
            host.send_byte(8'h00, ack);
            host.edge_cond(1'b0);
        end
        check(x6, 1);
        msg = '{8'h00};
        wr(8'h4A, 1);
        wr(8'h49, 1);
        msg = '{8'h0C, 8'h10, 8'h01, 8'(PER), 8'h00};
        wr(8'h01, 5);
        check(after_rand, 1);
        rdn(8'h01, 5);
        // Readable and write-only neighbours
        for (i = 0; i < 4; i = i + 1)
        begin
            msg = '{tbl[i][15:8], tbl[i][7:0]};
            rdn(tbl[i][23:16], 2);
        end
        // Encoded burst, t = 1, K = 16, filler in the check slots
        msg = {};
        p1 = 8'h00;
        p0 = 8'h00;
        for (i = 0; i < 16; i = i + 1)
        begin
            msg.push_back(8'(i * 27 + 53));
            fb = msg[i] ^ p1;
            p1 = p0 ^ gmul(fb, 8'h03);
            p0 = gmul(fb, 8'h02);
        end
        msg.push_back(8'h5A);
        msg.push_back(8'hC3);
        got = {};
        throttle <= 1'b1; // Slow receiver, check bytes must wait for room
        burst(18);
        throttle <= 1'b0;
        check(got.size(), 18);
        for (i = 0; i < 18; i = i + 1)
            check(got[i], i < 16 ? msg[i] : (i == 16 ? p1 : p0));
        // Pass-through by pin with t = 0; receiver stalls until the buffer refuses
        msg = '{8'h00, 8'h10, 8'h00};
        wr(8'h01, 3);
        fec_pin <= !fec_pin;
        hold <= 1'b1;
        msg = '{8'hA5, 8'h3C, 8'h96};
        got = {};
        burst(3);
        check(overflow, 1);
        hold <= 1'b0;
        repeat (6) @(posedge clk);
        check(got.size(), 2);
        check(got[0], 8'hA5);
        check(got[1], 8'h3C);
        // Three resets, then the control register comes back cleared
        repeat (3)
        begin
            resetn <= !resetn;
            repeat (2) @(posedge clk);
            resetn <= !resetn;
            repeat (4) @(posedge clk);
        end
        check(x6, 0);
        check(overflow, 0);
        check(byte_valid, 0);
        // Frozen by the clock enable, the device must not answer
        ce <= !ce;
        host.edge_cond(1'b1);
        host.send_byte({5'h00, 1'b1, addr_sel, 1'b0}, ack);
        check(ack, 0);
        host.edge_cond(1'b0);
        ce <= !ce;
        check(x6, 0);
        addr_sel <= !addr_sel;
        msg = '{8'h00};
        rdn(8'h48, 1);
        msg = '{8'h01};
        wr(8'h48, 1);
        check(x6, 1);
        conclude;
    end
endmodule // test_mcbf_top
